// file: logic/itc_cam_cmp.sv
`timescale 1ns/1ns
// one cam track: registered window test with wrap-around
module itc_cam_cmp
    import itc_pkg::*;
#(
    parameter int POS_W = POS_W_DEF
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // position to test and window edges
    input  wire logic [POS_W-1:0] pos,
    input  wire logic [POS_W-1:0] on_pt,
    input  wire logic [POS_W-1:0] off_pt,
    // track state
    output logic                  hit_r
);
    logic hit_nxt;

    // window may wrap through zero, so off below on is legal
    assign hit_nxt = (on_pt <= off_pt) ? (pos >= on_pt && pos < off_pt)
                                       : (pos >= on_pt || pos < off_pt);

    // output register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hit_r <= 1'b0;
        end else begin
            hit_r <= hit_nxt;
        end
    end
endmodule

// file: logic/itc_pkg.sv
// Contract
// RULE1 - each controller cycle, recompute required shift from current speed
// RULE2 - three methods: path-dependent, time-controlled, direct; path-dependent is default
// RULE3 - path mode: applied shift steps at most one increment per position change
// RULE4 - path mode: applied shift changes only while position changes; frozen at standstill
// RULE5 - time mode: applied shift steps at most one increment per controller cycle
// RULE6 - direct mode: required shift loaded into applied shift every cycle
// RULE7 - recalculation period in ms equals highest compensated output number
// RULE8 - user should place compensated tracks on lowest outputs for fastest update
// RULE9 - compensated outputs compare at position plus shift; others at plain position
package itc_pkg;
    // system clock and the controller time base
    localparam int CLK_FREQ_HZ    = 50_000_000;
    localparam int CTRL_CYCLE_US  = 1000;
    localparam int CTRL_CYCLE_CYC = (CLK_FREQ_HZ / 1_000_000) * CTRL_CYCLE_US;

    // default geometry
    localparam int N_OUT_DEF  = 16;
    localparam int POS_W_DEF  = 16;
    localparam int SPD_W_DEF  = 16;
    localparam int IDLE_W_DEF = 8;

    // applied shift after reset
    localparam logic [15:0] SHIFT_RST = 16'h0000;

    // compensation methods; the unused code falls back to path-dependent
    typedef enum logic [1:0] {
        ITC_PATH   = 2'b00,
        ITC_TIME   = 2'b01,
        ITC_DIRECT = 2'b10
    } itc_mode_e;
endpackage

// file: logic/itc_top.sv
`timescale 1ns/1ns
// idle-time compensation: shift tracking and compensated cam outputs
module itc_top
    import itc_pkg::*;
#(
    parameter int N_OUT  = N_OUT_DEF,
    parameter int POS_W  = POS_W_DEF,
    parameter int SPD_W  = SPD_W_DEF,
    parameter int IDLE_W = IDLE_W_DEF,
    parameter int MS_CYC = CTRL_CYCLE_CYC
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    nrst,
    // encoder position from pins
    input  wire logic [POS_W-1:0]        enc_pos,
    // speed and configuration from controller logic
    input  wire logic signed [SPD_W-1:0] speed,
    input  wire logic [IDLE_W-1:0]       idle_time,
    input  wire logic [1:0]              mode,
    input  wire logic [N_OUT-1:0]        comp_en,
    // cam windows, output i at bits [i*POS_W +: POS_W]
    input  wire logic [N_OUT*POS_W-1:0]  on_pts,
    input  wire logic [N_OUT*POS_W-1:0]  off_pts,
    // results
    output logic [N_OUT-1:0]             cam_out,
    output logic signed [POS_W-1:0]      act_shift_r,
    output logic signed [POS_W-1:0]      req_shift_r,
    output logic                         calc_tick_r
);
    localparam int MW = $clog2(MS_CYC);
    localparam int OW = $clog2(N_OUT + 1);
    localparam int PW = SPD_W + IDLE_W + 1;

    // encoder sync; a binary count can tear across bits, feed gray or a held value
    logic [POS_W-1:0] enc_s1_r;
    logic [POS_W-1:0] enc_s2_r;
    logic [POS_W-1:0] enc_prev_r;
    logic [MW-1:0]    ms_cnt_r;
    logic [OW-1:0]    per_cnt_r;
    logic [OW-1:0]    hi_out;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            enc_s1_r   <= '0;
            enc_s2_r   <= '0;
            enc_prev_r <= '0;
        end else begin
            enc_s1_r   <= enc_pos;
            enc_s2_r   <= enc_s1_r;
            enc_prev_r <= enc_s2_r;
        end
    end

    // decode of movement, time base and method
    logic      pos_moved;
    logic      ms_tick;
    logic      calc_nxt;
    itc_mode_e mode_w;
    logic      is_time;
    logic      is_direct;
    logic      is_path;

    assign pos_moved = enc_s2_r != enc_prev_r;
    assign ms_tick   = ms_cnt_r == MW'(MS_CYC - 1);
    assign mode_w    = itc_mode_e'(mode);
    assign is_time   = mode_w == ITC_TIME;
    assign is_direct = mode_w == ITC_DIRECT;
    assign is_path   = !is_time && !is_direct; // RULE2

    // highest compensated output number, 1 when none is enabled
    always_comb begin
        hi_out = OW'(1);
        for (int i = 0; i < N_OUT; i++) begin
            if (comp_en[i]) begin
                hi_out = OW'(i + 1); // RULE7
            end
        end
    end

    // one calculation every hi_out milliseconds
    assign calc_nxt = ms_tick && (per_cnt_r >= hi_out - OW'(1)); // RULE7

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + MW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            per_cnt_r   <= '0;
            calc_tick_r <= 1'b0;
        end else begin
            calc_tick_r <= calc_nxt;
            if (calc_nxt) begin
                per_cnt_r <= '0; // RULE7
            end else if (ms_tick) begin
                per_cnt_r <= per_cnt_r + OW'(1);
            end
        end
    end

    // required shift = speed (incr/ms) times idle time (ms)
    logic signed [PW-1:0]    req_full;
    logic signed [POS_W-1:0] req_nxt;

    assign req_full = PW'(speed) * $signed({1'b0, idle_time}); // RULE1
    assign req_nxt  = req_full[POS_W-1:0];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_shift_r <= '0;
        end else if (calc_nxt) begin
            req_shift_r <= req_nxt; // RULE1
        end
    end

    // single-increment brake toward a target
    logic signed [POS_W-1:0] tgt;
    logic signed [POS_W-1:0] stepped;
    logic signed [POS_W-1:0] act_nxt;

    assign tgt     = is_path ? req_shift_r : req_nxt;
    assign stepped = (tgt > act_shift_r) ? act_shift_r + POS_W'(1)
                   : (tgt < act_shift_r) ? act_shift_r - POS_W'(1)
                   : act_shift_r; // RULE3 RULE5

    // path steps on movement only, so it can freeze wrong at a hard stop
    always_comb begin
        case (mode_w)
            ITC_TIME:   act_nxt = calc_nxt ? stepped : act_shift_r; // RULE5
            ITC_DIRECT: act_nxt = calc_nxt ? req_nxt : act_shift_r; // RULE6
            ITC_PATH:   act_nxt = pos_moved ? stepped : act_shift_r; // RULE3 RULE4
            default:    act_nxt = pos_moved ? stepped : act_shift_r; // RULE2
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            act_shift_r <= SHIFT_RST[POS_W-1:0];
        end else begin
            act_shift_r <= act_nxt;
        end
    end

    // per-track compare position, advanced only where compensation is on
    logic [POS_W-1:0] cmp_pos [N_OUT];

    generate
        for (genvar g = 0; g < N_OUT; g++) begin : g_trk
            assign cmp_pos[g] = comp_en[g] ? enc_s2_r + POS_W'(act_shift_r)
                                           : enc_s2_r; // RULE9
            itc_cam_cmp #(
                .POS_W (POS_W)
            ) u_cmp (
                .clk    (clk),
                .nrst   (nrst),
                .pos    (cmp_pos[g]),
                .on_pt  (on_pts[g*POS_W +: POS_W]),
                .off_pt (off_pts[g*POS_W +: POS_W]),
                .hit_r  (cam_out[g])
            );
            cmp_shift_a: assert property (@(posedge clk) disable iff (!nrst) // RULE9
                comp_en[g] |-> cmp_pos[g] == enc_s2_r + POS_W'(act_shift_r))
                else $error("compensated track not advanced by shift");
        end
    endgenerate

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // helper: gap between calculations, spoiled when the enable set changes
    int   gap_r;
    logic seen_r;
    logic en_chg_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap_r    <= 0;
            seen_r   <= 1'b0;
            en_chg_r <= 1'b0;
        end else begin
            gap_r    <= calc_tick_r ? 1 : gap_r + 1;
            seen_r   <= seen_r | calc_tick_r;
            en_chg_r <= calc_tick_r ? 1'b0 : (en_chg_r | (comp_en != $past(comp_en)));
        end
    end

    sequence path_move_s;
        is_path && pos_moved;
    endsequence
    sequence path_still_s;
        is_path && !pos_moved;
    endsequence

    req_recalc_a: assert property (calc_nxt |=> req_shift_r == $past(req_nxt)) // RULE1
        else $error("required shift not recomputed");
    spare_path_a: assert property ((mode == 2'b11) ##0 path_still_s |=> $stable(act_shift_r)) // RULE2
        else $error("unused mode code not treated as path");
    path_step_a: assert property (path_move_s |=> // RULE3
        (act_shift_r - $past(act_shift_r) == POS_W'(1)) ||
        ($past(act_shift_r) - act_shift_r == POS_W'(1)) ||
        (act_shift_r == $past(req_shift_r)))
        else $error("path step larger than one increment");
    path_freeze_a: assert property (path_still_s [*2] |=> $stable(act_shift_r)) // RULE4
        else $error("shift moved at standstill");
    time_step_a: assert property ((is_time && calc_nxt && req_nxt != act_shift_r) |=> // RULE5
        (act_shift_r != $past(act_shift_r)) &&
        ((act_shift_r - $past(act_shift_r) == POS_W'(1)) ||
         ($past(act_shift_r) - act_shift_r == POS_W'(1))))
        else $error("timed step not exactly one increment");
    time_hold_a: assert property ((is_time && !calc_nxt) |=> $stable(act_shift_r)) // RULE5
        else $error("timed shift moved between cycles");
    direct_load_a: assert property ((is_direct && calc_nxt) |=> act_shift_r == $past(req_nxt)) // RULE6
        else $error("direct load missed");
    // an enable change sampled at the closing edge is not yet in en_chg_r
    calc_period_a: assert property ((calc_tick_r && seen_r && !en_chg_r) && // RULE7
        $stable(comp_en) |-> gap_r == int'(hi_out) * MS_CYC)
        else $error("recalculation period wrong");
endmodule

// file: tb/itc_enc_model.sv
`timescale 1ns/1ns
// encoder stand-in: parallel position word, one increment per step
module itc_enc_model #(
    parameter int POS_W = 16
) (
    // clock
    input  wire logic             clk,
    // commands from the bench
    input  wire logic             step,
    input  wire logic             dir,
    input  wire logic             load,
    input  wire logic [POS_W-1:0] load_val,
    // position word to the pins
    output logic [POS_W-1:0]      pos
);
    logic [POS_W-1:0] pos_r = '0;

    // one process owns the word; the port only mirrors it
    assign pos = pos_r;

    // moves just after the edge, so the word never changes as it is sampled
    always @(posedge clk) begin
        if (load) begin
            pos_r <= load_val;
        end else if (step) begin
            pos_r <= dir ? pos_r + 1'b1 : pos_r - 1'b1;
        end
    end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
// shift tracking, period and compensated cam checks
module testbench;
    import itc_pkg::*;
    localparam int MS = 4;
    logic               clk = 1'b0;
    logic               nrst = 1'b0;
    logic signed [15:0] speed, act_shift_r, req_shift_r, act_m, req_m;
    logic [7:0]         idle_time;
    logic [1:0]         mode;
    logic [15:0]        comp_en, cam_out, load_val, enc_pos;
    logic [255:0]       on_pts, off_pts;
    logic               calc_tick_r, step, dir, load;
    logic [31:0]        exp_q[$];
    logic [31:0]        e;
    logic [15:0]        pv[5] = '{16'h0001, 16'h000F, 16'h6A00, 16'h8000, 16'h0000};
    int                 ph[5] = '{1, 4, 15, 16, 1};
    int                 err_total = 0;
    int                 samples_checked = 0;
    int                 seed = 32'hA4EB;
    int                 n;

    always #10 clk = ~clk;

    itc_top #(.MS_CYC(MS)) u_itc_top (.clk(clk), .nrst(nrst), .enc_pos(enc_pos),
        .speed(speed), .idle_time(idle_time), .mode(mode), .comp_en(comp_en),
        .on_pts(on_pts), .off_pts(off_pts), .cam_out(cam_out),
        .act_shift_r(act_shift_r), .req_shift_r(req_shift_r), .calc_tick_r(calc_tick_r));
    itc_enc_model u_itc_enc_model (.clk(clk), .step(step), .dir(dir), .load(load),
        .load_val(load_val), .pos(enc_pos));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // bounded wait for the next recalculation pulse; n is cycles waited
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (calc_tick_r !== 1'b1 && c < 400);
        if (c >= 400) begin
            err_total++;
            summarize();
        end
    endtask

    // one controller cycle: new speed, note expectation, move encoder
    task automatic tick_step(input logic [1:0] m, input int nst);
        logic signed [15:0] p;
        #1;
        speed = 16'($random(seed) % 20);
        idle_time = 8'($unsigned($random(seed)) % 10);
        p = 16'(speed * $signed({8'h00, idle_time}));
        mode = m;
        if (m == ITC_DIRECT) act_m = p;
        else if (m == ITC_TIME && act_m != p) act_m = (p > act_m) ? act_m + 1 : act_m - 1;
        else if (m != ITC_TIME) begin
            // path: one increment per position change, toward last registered target
            for (int i = 0; i < nst; i++)
                if (act_m != req_m) act_m = (req_m > act_m) ? act_m + 1 : act_m - 1;
        end
        exp_q.push_back({p, act_m});
        req_m = p;
        for (int i = 0; i < nst; i++) begin
            step = 1'b1;
            dir = 1'($random(seed));
            @(negedge clk);
            step = 1'b0;
            repeat (3) @(negedge clk);
        end
        wait_tick(n);
    endtask

    // scoreboard: each pulse takes the oldest note
    always @(negedge clk) begin
        if (nrst && calc_tick_r === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check("req_shift", {16'h0000, req_shift_r}, {16'h0000, e[31:16]});
            check("act_shift", $unsigned(act_shift_r), e[15:0]);
        end
    end

    // main sequence
    initial begin
        speed = '0;
        idle_time = '0;
        mode = ITC_PATH;
        comp_en = 16'h0010;
        on_pts = {8{$random(seed)}};
        off_pts = {8{$random(seed)}};
        {step, dir, load, load_val, act_m, req_m} = '0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        check("act_rst", {16'h0000, act_shift_r}, 32'h0000_0000);
        check("req_rst", {16'h0000, req_shift_r}, 32'h0000_0000);
        wait_tick(n);
        // modes path, time, direct, unused code; some cycles at standstill
        for (int r = 0; r < 24; r++)
            tick_step(2'(r / 6), (r % 3 == 0) ? 0 : 1 + $unsigned($random(seed)) % 3);
        // period follows the highest compensated output; second gap is settled
        for (int k = 0; k < 5; k++) begin
            comp_en = pv[k];
            wait_tick(n);
            wait_tick(n);
            check("period", 32'(n), 32'(MS * ph[k]));
        end
        // track 0 compensated, track 1 plain, same window
        comp_en = 16'h0001;
        mode = ITC_DIRECT;
        speed = 16'h0004;
        idle_time = 8'h05;
        on_pts[31:0] = {16'h0064, 16'h0064};
        off_pts[31:0] = {16'h006E, 16'h006E};
        wait_tick(n);
        wait_tick(n);
        for (int k = 0; k < 2; k++) begin
            load = 1'b1;
            load_val = k ? 16'h0069 : 16'h0055;
            @(negedge clk);
            load = 1'b0;
            repeat (5) @(negedge clk);
            check("cam_out", {30'h0, cam_out[1:0]}, k ? 32'h2 : 32'h1);
        end
        summarize();
    end
endmodule
